// ---- logic/isc_pkg.sv ----
package isc_pkg;

  // Cycle kinds
  typedef enum logic [2:0] {
    ISC_FETCH,
    ISC_BRANCH_READ,
    ISC_STACK,
    ISC_BYTE,
    ISC_WORD,
    ISC_INTERNAL
  } isc_kind_t;

  localparam int ISC_NUM_KINDS = 6;

  // Access target of a cycle
  typedef enum logic [2:0] {
    ISC_ONCHIP_MEM,
    ISC_MODULE_8,
    ISC_MODULE_16,
    ISC_EXT8_2ST,
    ISC_EXT8_3ST,
    ISC_EXT16_2ST,
    ISC_EXT16_3ST
  } isc_target_t;

  // Instruction classes the sequencer understands
  typedef enum logic [2:0] {
    ISC_OP_GENERIC,
    ISC_OP_BLOCK_MOVE,
    ISC_OP_BRANCH_D16,
    ISC_OP_TRAP_NORMAL,
    ISC_OP_TRAP_ADVANCED
  } isc_op_t;

  // Ten bits so a block move's 2n+2 byte count never clips
  localparam int ISC_CNT_W   = 10;
  localparam int ISC_MOVE_W  = 8;
  localparam int ISC_WAIT_W  = 4;
  localparam int ISC_STATE_W = 16;

  // Per-kind costs
  localparam logic [ISC_STATE_W-1:0] ISC_ST_ONCHIP     = 16'h0002;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_FETCH_M8   = 16'h0006;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_FETCH_M16  = 16'h0003;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_FETCH_E8   = 16'h0004;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_FETCH_E8_3 = 16'h0006;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_E16_2      = 16'h0002;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_E16_3      = 16'h0003;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_BYTE_M8    = 16'h0003;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_BYTE_E8    = 16'h0002;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_BYTE_E8_3  = 16'h0003;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_WORD_M8    = 16'h0006;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_WORD_E8    = 16'h0004;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_WORD_E8_3  = 16'h0006;
  localparam logic [ISC_STATE_W-1:0] ISC_ST_INTERNAL   = 16'h0001;

  // Fixed instruction profiles
  localparam logic [ISC_CNT_W-1:0] ISC_BRANCH_FETCH   = 10'h002;
  localparam logic [ISC_CNT_W-1:0] ISC_BRANCH_INT     = 10'h002;
  localparam logic [ISC_CNT_W-1:0] ISC_BMOVE_FETCH    = 10'h002;
  localparam logic [ISC_CNT_W-1:0] ISC_BMOVE_EXTRA    = 10'h002;
  localparam logic [ISC_CNT_W-1:0] ISC_TRAP_FETCH     = 10'h002;
  localparam logic [ISC_CNT_W-1:0] ISC_TRAP_BR_NORMAL = 10'h001;
  localparam logic [ISC_CNT_W-1:0] ISC_TRAP_BR_ADV    = 10'h002;
  localparam logic [ISC_CNT_W-1:0] ISC_TRAP_STACK     = 10'h002;
  localparam logic [ISC_CNT_W-1:0] ISC_TRAP_INT       = 10'h004;

  // Counts of each kind for one instruction
  typedef struct packed {
    logic [ISC_CNT_W-1:0] fetch;
    logic [ISC_CNT_W-1:0] branch_read;
    logic [ISC_CNT_W-1:0] stack;
    logic [ISC_CNT_W-1:0] byte_acc;
    logic [ISC_CNT_W-1:0] word_acc;
    logic [ISC_CNT_W-1:0] internal;
  } isc_counts_t;

  // Where each kind of cycle goes
  typedef struct packed {
    isc_target_t                 code_tgt;
    isc_target_t                 stack_tgt;
    isc_target_t                 data_tgt;
    logic [ISC_WAIT_W-1:0]       wait_states;
  } isc_access_t;

endpackage

// ---- logic/isc_cost.sv ----
`timescale 1ns/1ps
module isc_cost
  import isc_pkg::*;
(
  // Cycle description
  input  wire isc_kind_t             kind,
  input  wire isc_target_t           target,
  input  wire logic [ISC_WAIT_W-1:0] wait_states,
  // States per cycle
  output logic [ISC_STATE_W-1:0]     cost
);

  logic [ISC_STATE_W-1:0] m;
  assign m = {{(ISC_STATE_W-ISC_WAIT_W){1'b0}}, wait_states};

  // Cost depends on kind, target and wait states only, not on the opcode
  always_comb
  begin
    cost = ISC_ST_ONCHIP;
    if (kind == ISC_INTERNAL)
    begin
      cost = ISC_ST_INTERNAL;
    end
    else
    begin
      case (target)
        ISC_ONCHIP_MEM: cost = ISC_ST_ONCHIP;
        ISC_MODULE_8:
          if (kind == ISC_BYTE)
            cost = ISC_ST_BYTE_M8;
          else if (kind == ISC_WORD)
            cost = ISC_ST_WORD_M8;
          else
            cost = ISC_ST_FETCH_M8;
        ISC_MODULE_16:  cost = ISC_ST_FETCH_M16;
        ISC_EXT8_2ST:
          if (kind == ISC_BYTE)
            cost = ISC_ST_BYTE_E8;
          else
            cost = ISC_ST_FETCH_E8;
        ISC_EXT8_3ST:
          if (kind == ISC_BYTE)
            cost = ISC_ST_BYTE_E8_3 + m;
          else
            cost = ISC_ST_FETCH_E8_3 + (m << 1);
        ISC_EXT16_2ST:  cost = ISC_ST_E16_2;
        ISC_EXT16_3ST:  cost = ISC_ST_E16_3 + m;
        default:        cost = ISC_ST_ONCHIP;
      endcase
    end
  end

endmodule

// ---- logic/isc_profile.sv ----
`timescale 1ns/1ps
module isc_profile
  import isc_pkg::*;
(
  // Instruction description
  input  wire isc_op_t               op,
  input  wire isc_counts_t           generic_counts,
  input  wire logic [ISC_MOVE_W-1:0] move_count_low_byte,
  // Resulting counts
  output isc_counts_t                counts
);

  logic [ISC_CNT_W-1:0] moves;

  always_comb
  begin
    // Source and destination each touched n + 1 times
    moves  = ISC_CNT_W'({move_count_low_byte, 1'b0}) + ISC_BMOVE_EXTRA;
    counts = generic_counts;
    case (op)
      ISC_OP_BLOCK_MOVE:
      begin
        counts          = '0;
        counts.fetch    = ISC_BMOVE_FETCH;
        counts.byte_acc = moves;
      end
      ISC_OP_BRANCH_D16:
      begin
        counts          = '0;
        counts.fetch    = ISC_BRANCH_FETCH;
        counts.internal = ISC_BRANCH_INT;
      end
      ISC_OP_TRAP_NORMAL, ISC_OP_TRAP_ADVANCED:
      begin
        counts             = '0;
        counts.fetch       = ISC_TRAP_FETCH;
        counts.branch_read = (op == ISC_OP_TRAP_NORMAL) ? ISC_TRAP_BR_NORMAL
                                                        : ISC_TRAP_BR_ADV;
        counts.stack       = ISC_TRAP_STACK;
        counts.internal    = ISC_TRAP_INT;
      end
      default: counts = generic_counts;
    endcase
  end

endmodule

// ---- logic/isc_counter.sv ----
`timescale 1ns/1ps
module isc_counter
  import isc_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  // Instruction request
  input  wire logic                    start,
  input  wire isc_op_t                 op,
  input  wire isc_counts_t             generic_counts,
  input  wire logic [ISC_MOVE_W-1:0]   move_count_low_byte,
  input  wire isc_access_t             access,
  // Result
  output logic                         busy,
  output logic                         done,
  output logic [ISC_STATE_W-1:0]       total_states,
  output isc_counts_t                  cycle_counts,
  output logic                         exec_active
);

  typedef enum logic [1:0] {ISC_IDLE, ISC_SUM, ISC_EXEC} isc_state_t;

  isc_state_t             state, next_state;
  isc_counts_t            prof_counts;
  isc_counts_t            next_cycle_counts;
  isc_access_t            acc_q, next_acc_q;
  logic [2:0]             kind_idx, next_kind_idx;
  logic [ISC_STATE_W-1:0] next_total_states;
  logic [ISC_STATE_W-1:0] remain, next_remain;
  logic                   next_busy, next_done, next_exec_active;
  logic [ISC_STATE_W-1:0] kind_cost;
  isc_target_t            kind_tgt;
  isc_kind_t              cur_kind;
  logic [ISC_CNT_W-1:0]   cur_count;
  logic [ISC_STATE_W-1:0] product;

  // Count field of a kind, indexed
  function automatic logic [ISC_CNT_W-1:0] count_of(input isc_counts_t c, input logic [2:0] k);
    case (k)
      3'h0:    count_of = c.fetch;
      3'h1:    count_of = c.branch_read;
      3'h2:    count_of = c.stack;
      3'h3:    count_of = c.byte_acc;
      3'h4:    count_of = c.word_acc;
      default: count_of = c.internal;
    endcase
  endfunction

  isc_profile u_profile (
    .op                  (op),
    .generic_counts      (generic_counts),
    .move_count_low_byte (move_count_low_byte),
    .counts              (prof_counts)
  );

  assign cur_kind  = isc_kind_t'(kind_idx);
  assign cur_count = count_of(cycle_counts, kind_idx);

  // Code-side kinds follow the code area, stack the stack area
  always_comb
  begin
    case (cur_kind)
      ISC_FETCH, ISC_BRANCH_READ: kind_tgt = acc_q.code_tgt;
      ISC_STACK:                  kind_tgt = acc_q.stack_tgt;
      default:                    kind_tgt = acc_q.data_tgt;
    endcase
  end

  isc_cost u_cost (
    .kind        (cur_kind),
    .target      (kind_tgt),
    .wait_states (acc_q.wait_states),
    .cost        (kind_cost)
  );

  // Narrow product; counts and costs stay small in practice
  assign product = ISC_STATE_W'({{(ISC_STATE_W-ISC_CNT_W){1'b0}}, cur_count} * kind_cost);

  always_comb
  begin
    next_state        = state;
    next_cycle_counts = cycle_counts;
    next_acc_q        = acc_q;
    next_kind_idx     = kind_idx;
    next_total_states = total_states;
    next_remain       = remain;
    next_busy         = busy;
    next_done         = 1'b0;
    next_exec_active  = exec_active;
    case (state)
      ISC_IDLE:
      begin
        if (start)
        begin
          next_cycle_counts = prof_counts;
          next_acc_q        = access;
          next_kind_idx     = 3'h0;
          next_total_states = '0;
          next_busy         = 1'b1;
          next_state        = ISC_SUM;
        end
      end
      ISC_SUM:
      begin
        next_total_states = total_states + product;
        if (kind_idx == 3'(ISC_NUM_KINDS - 1))
        begin
          next_remain      = total_states + product;
          next_exec_active = ((total_states + product) != '0);
          next_state       = ISC_EXEC;
          if ((total_states + product) == '0)
          begin
            next_busy  = 1'b0;
            next_done  = 1'b1;
            next_state = ISC_IDLE;
          end
        end
        else
        begin
          next_kind_idx = kind_idx + 3'h1;
        end
      end
      ISC_EXEC:
      begin
        // One state per clock period
        next_remain = remain - 16'h0001;
        if (remain == 16'h0001)
        begin
          next_exec_active = 1'b0;
          next_busy        = 1'b0;
          next_done        = 1'b1;
          next_state       = ISC_IDLE;
        end
      end
      default: next_state = ISC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state        <= ISC_IDLE;
      cycle_counts <= '0;
      acc_q        <= '0;
      kind_idx     <= 3'h0;
      total_states <= '0;
      remain       <= '0;
      busy         <= 1'b0;
      done         <= 1'b0;
      exec_active  <= 1'b0;
    end
    else if (clk_en)
    begin
      state        <= next_state;
      cycle_counts <= next_cycle_counts;
      acc_q        <= next_acc_q;
      kind_idx     <= next_kind_idx;
      total_states <= next_total_states;
      remain       <= next_remain;
      busy         <= next_busy;
      done         <= next_done;
      exec_active  <= next_exec_active;
    end
  end

endmodule

// ---- dv/isc_counter_checker.sv ----
`timescale 1ns/1ps
module isc_counter_checker
  import isc_pkg::*;
(
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic                   clk_en,
  // Request
  input wire logic                   start,
  input wire isc_op_t                op,
  input wire isc_counts_t            generic_counts,
  input wire logic [ISC_MOVE_W-1:0]  move_count_low_byte,
  input wire isc_access_t            access,
  // Result
  input wire logic                   busy,
  input wire logic                   done,
  input wire logic [ISC_STATE_W-1:0] total_states,
  input wire isc_counts_t            cycle_counts,
  input wire logic                   exec_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  wire take = start & ~busy & clk_en;

  take_busy_a: assert property (take |=> busy)
    else $error("busy not raised after start");
  done_pulse_a: assert property (done && clk_en |=> !done)
    else $error("done longer than one cycle");
  total_hold_a: assert property (exec_active |=> $stable(total_states))
    else $error("total moved while executing");
  exec_end_a: assert property ($fell(exec_active) && !$past(rst) |-> ##[0:1] done)
    else $error("no done after execution window");
  branch_prof_a: assert property (take && op == ISC_OP_BRANCH_D16 |=>
    cycle_counts == {10'h002, 10'h000, 10'h000, 10'h000, 10'h000, 10'h002})
    else $error("long branch counts off");
  trap_prof_a: assert property (take && op == ISC_OP_TRAP_NORMAL |=>
    cycle_counts == {10'h002, 10'h001, 10'h002, 10'h000, 10'h000, 10'h004})
    else $error("trap counts off");
  move_prof_a: assert property (take && op == ISC_OP_BLOCK_MOVE |=>
    cycle_counts.byte_acc == {1'b0, $past(move_count_low_byte), 1'b0} + 10'h002
    && cycle_counts.fetch == 10'h002) else $error("move count off");
  generic_prof_a: assert property (take && op == ISC_OP_GENERIC |=>
    cycle_counts == $past(generic_counts)) else $error("generic counts not latched");
  internal_cost_a: assert property (take && op == ISC_OP_GENERIC
    && generic_counts[59:10] == 50'h0
    |-> ##7 total_states == 16'($past(generic_counts.internal, 7)))
    else $error("internal cost off");
endmodule

bind isc_counter isc_counter_checker i_chk (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
  .start(start), .op(op), .generic_counts(generic_counts),
  .move_count_low_byte(move_count_low_byte), .access(access), .busy(busy), .done(done),
  .total_states(total_states), .cycle_counts(cycle_counts), .exec_active(exec_active));

// ---- dv/isc_counter_test.sv ----
`timescale 1ns/1ps
module isc_counter_test
  import isc_pkg::*;
;
  typedef struct packed {
    isc_op_t               op;
    // Counts written as six bytes, widened on use
    logic [5:0][7:0]       c;
    logic [ISC_MOVE_W-1:0] n;
    isc_access_t           a;
  } isc_row_t;

  logic                   ref_clk;
  logic                   rst;
  logic                   clk_en;
  logic                   start;
  isc_op_t                op;
  isc_counts_t            generic_counts;
  logic [ISC_MOVE_W-1:0]  move_count_low_byte;
  isc_access_t            access;
  logic                   busy;
  logic                   done;
  logic [ISC_STATE_W-1:0] total_states;
  isc_counts_t            cycle_counts;
  logic                   exec_active;
  int                     fails;
  int                     samples_checked;
  int                     cyc;

  `define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

  // Junk counts on the non-generic rows, bar the advanced trap row, prove they are ignored
  isc_row_t rows [11] = '{
    '{ISC_OP_GENERIC, 48'h020000020000, 8'h00, '{ISC_EXT16_3ST, ISC_EXT16_3ST, ISC_MODULE_8, 4'h1}},
    '{ISC_OP_GENERIC, 48'h020202000000, 8'h00, '{ISC_EXT16_3ST, ISC_EXT16_3ST, ISC_EXT16_3ST, 4'h1}},
    '{ISC_OP_GENERIC, 48'h010101010103, 8'h00, '{ISC_ONCHIP_MEM, ISC_MODULE_16, ISC_EXT8_2ST, 4'h0}},
    '{ISC_OP_GENERIC, 48'h0100010101FF, 8'h00, '{ISC_EXT8_3ST, ISC_EXT16_2ST, ISC_EXT8_3ST, 4'hF}},
    '{ISC_OP_BLOCK_MOVE, 48'h090909090909, 8'hFF, '{ISC_ONCHIP_MEM, ISC_ONCHIP_MEM, ISC_ONCHIP_MEM, 4'h0}},
    '{ISC_OP_BLOCK_MOVE, 48'h090909090909, 8'h00, '{ISC_MODULE_16, ISC_EXT16_2ST, ISC_EXT8_3ST, 4'h3}},
    '{ISC_OP_BRANCH_D16, 48'h090909090909, 8'h05, '{ISC_MODULE_8, ISC_MODULE_8, ISC_MODULE_8, 4'h0}},
    '{ISC_OP_TRAP_NORMAL, 48'h090909090909, 8'h05, '{ISC_EXT8_2ST, ISC_EXT8_3ST, ISC_MODULE_8, 4'h2}},
    '{ISC_OP_TRAP_ADVANCED, 48'h0, 8'h00, '{ISC_EXT16_2ST, ISC_MODULE_8, ISC_ONCHIP_MEM, 4'h0}},
    '{ISC_OP_GENERIC, 48'h000000000005, 8'h00, '{ISC_EXT8_3ST, ISC_EXT8_3ST, ISC_EXT8_3ST, 4'h7}},
    '{ISC_OP_GENERIC, 48'h010000000100, 8'h00, '{ISC_ONCHIP_MEM, ISC_ONCHIP_MEM, ISC_MODULE_8, 4'h0}}
  };

  isc_counter i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .start(start), .op(op),
    .generic_counts(generic_counts), .move_count_low_byte(move_count_low_byte),
    .access(access), .busy(busy), .done(done), .total_states(total_states),
    .cycle_counts(cycle_counts), .exec_active(exec_active));

  function automatic logic [15:0] cst(isc_target_t t, bit b, logic [3:0] m);
    case (t)
      ISC_ONCHIP_MEM, ISC_EXT16_2ST: cst = 16'h0002;
      ISC_MODULE_8: cst = b ? 16'h0003 : 16'h0006;
      ISC_MODULE_16: cst = 16'h0003;
      ISC_EXT8_2ST: cst = b ? 16'h0002 : 16'h0004;
      ISC_EXT8_3ST: cst = b ? 16'h0003 + 16'(m) : 16'h0006 + 16'h0002 * 16'(m);
      default: cst = 16'h0003 + 16'(m);
    endcase
  endfunction

  function automatic isc_counts_t widen_counts(logic [5:0][7:0] b);
    return {ISC_CNT_W'(b[5]), ISC_CNT_W'(b[4]), ISC_CNT_W'(b[3]),
      ISC_CNT_W'(b[2]), ISC_CNT_W'(b[1]), ISC_CNT_W'(b[0])};
  endfunction

  function automatic isc_counts_t ecnt(isc_row_t r);
    isc_counts_t c;
    c = widen_counts(r.c);
    if (r.op != ISC_OP_GENERIC)
    begin
      c = '0;
      c.fetch = 10'h002;
    end
    if (r.op == ISC_OP_BRANCH_D16)
      c.internal = 10'h002;
    if (r.op == ISC_OP_TRAP_NORMAL || r.op == ISC_OP_TRAP_ADVANCED)
    begin
      c.branch_read = (r.op == ISC_OP_TRAP_ADVANCED) ? 10'h002 : 10'h001;
      c.stack = 10'h002;
      c.internal = 10'h004;
    end
    // Every move reads and writes n + 1 bytes
    if (r.op == ISC_OP_BLOCK_MOVE)
      c.byte_acc = {1'b0, r.n, 1'b0} + 10'h002;
    return c;
  endfunction

  function automatic logic [15:0] etot(isc_counts_t c, isc_access_t a);
    // Code cycles follow the code target, data kinds the data target
    return (16'(c.fetch) + 16'(c.branch_read)) * cst(a.code_tgt, 1'b0, a.wait_states)
      + 16'(c.stack) * cst(a.stack_tgt, 1'b0, a.wait_states)
      + 16'(c.byte_acc) * cst(a.data_tgt, 1'b1, a.wait_states)
      + 16'(c.word_acc) * cst(a.data_tgt, 1'b0, a.wait_states) + 16'(c.internal);
  endfunction

  task automatic run(input isc_row_t r, input bit odd);
    int ex;
    int k;
    op = r.op;
    generic_counts = widen_counts(r.c);
    move_count_low_byte = r.n;
    access = r.a;
    start = 1'b1;
    @(posedge ref_clk);
    #1 start = odd;
    op = ISC_OP_TRAP_ADVANCED;
    generic_counts = '1;
    if (odd)
    begin
      // Refused requests while busy, then a short freeze
      repeat (3) @(posedge ref_clk);
      #1 start = 1'b0;
      clk_en = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 clk_en = 1'b1;
    end
    ex = 0;
    for (k = 0; k < 2000 && done !== 1'b1; k++)
    begin
      if (exec_active === 1'b1) ex++;
      @(posedge ref_clk);
      #1;
    end
    `CHK("counts", ecnt(r), cycle_counts)
    `CHK("total", etot(ecnt(r), r.a), total_states)
    `CHK("exec cycles", etot(ecnt(r), r.a), 16'(ex))
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Whole run needs about 1700 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      give_verdict();
    end
  end

  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    start = 1'b0;
    op = ISC_OP_GENERIC;
    generic_counts = '0;
    move_count_low_byte = 8'h00;
    access = '0;
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'b0;
    // Rows run back to back: each start after the first lands in the done cycle
    for (int i = 0; i < 11; i++)
      run(rows[i], i == 3);
    op = ISC_OP_BLOCK_MOVE;
    move_count_low_byte = 8'hC8;
    start = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1 start = 1'b0;
    rst = 1'b1;
    @(posedge ref_clk);
    #1 rst = 1'b0;
    `CHK("reset", 19'h0, {busy, done, exec_active, total_states})
    run(rows[7], 1'b0);
    give_verdict();
  end
endmodule
